/* File: src/datalink_status_irq.v */
// Loss-of-signal enable and data-link status register bank, AXI4-Lite
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
module datalink_status_irq (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_los,
  input wire tx_start_event,
  input wire rx_start_event,
  input wire tx_end_event,
  input wire rx_message_done,
  input wire rx_message_kind,
  output reg irq
);
`include "datalink_status_irq_regs.vh"

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function [1:0] reg_index;
    input [7:0] addr;
    begin
      reg_index = addr[`ADDR_MSB-4:`ADDR_LSB];
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[`ADDR_MSB:`ADDR_MSB-3] == 4'h0)
        && (addr[`ADDR_LSB-1:0] == 2'h0);
    end
  endfunction

  function hits;
    input [7:0] addr;
    input [7:0] target;
    begin
      hits = mapped(addr) && (reg_index(addr) == reg_index(target));
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg los_enable_n;
  reg [2:0] dl_enable;
  reg message_kind;
  wire los_change;
  wire los_flag;
  wire tx_start_flag;
  wire rx_start_flag;
  wire tx_end_flag;
  wire read_take;
  wire clear_los;
  wire clear_dl;
  wire next_irq;
  reg [31:0] next_rdata;

  // ----------------------------------------------------------------
  // Write channel: address and data taken separately, either order
  // ----------------------------------------------------------------
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire aw_take;
  wire w_take;
  wire aw_have;
  wire w_have;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire wr_go;
  wire wr_ok;
  wire wr_los;
  wire wr_dl;

  // Readies fall with ce so no beat is taken while frozen
  assign s_axi_awready = ce & !aw_held & !s_axi_bvalid;
  assign s_axi_wready = ce & !w_held & !s_axi_bvalid;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign aw_have = aw_held | aw_take;
  assign w_have = w_held | w_take;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data = w_held ? w_data : s_axi_wdata;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb;
  assign wr_go = aw_have & w_have & !s_axi_bvalid & ce;
  // Only byte lane 0 carries register bits
  assign wr_ok = wr_go & wr_strb[0];
  assign wr_los = wr_ok && hits(wr_addr, `ADDR_LOS_IRQ_ENABLE);
  assign wr_dl = wr_ok && hits(wr_addr, `ADDR_DATALINK2_IRQ_ENABLE);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Enable registers; status registers ignore writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      los_enable_n <= `RST_LOS_ENABLE;
      dl_enable <= `RST_DL_ENABLE;
    end else begin
      if (wr_los) begin
        los_enable_n <= wr_data[`BIT_LOS_ENABLE];
      end
      if (wr_dl) begin
        dl_enable <= wr_data[`BIT_TX_START:`BIT_TX_END];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel: one cycle to rvalid
  // ----------------------------------------------------------------
  assign s_axi_arready = ce & !s_axi_rvalid;
  assign read_take = s_axi_arvalid & s_axi_arready;
  assign clear_los = read_take && hits(s_axi_araddr, `ADDR_LOS_STATUS);
  assign clear_dl = read_take && hits(s_axi_araddr, `ADDR_DATALINK2_STATUS);

  // Unmapped addresses and reserved bits read as zero
  always @* begin
    next_rdata = 32'h00000000;
    case (reg_index(s_axi_araddr))
      reg_index(`ADDR_LOS_IRQ_ENABLE): begin
        next_rdata[`BIT_LOS_ENABLE] = los_enable_n;
      end
      reg_index(`ADDR_DATALINK2_STATUS): begin
        next_rdata[`BIT_MESSAGE_KIND] = message_kind;
        next_rdata[`BIT_TX_START] = tx_start_flag;
        next_rdata[`BIT_RX_START] = rx_start_flag;
        next_rdata[`BIT_TX_END] = tx_end_flag;
      end
      reg_index(`ADDR_LOS_STATUS): begin
        next_rdata[`BIT_LOS_CHANGE] = los_flag;
      end
      reg_index(`ADDR_DATALINK2_IRQ_ENABLE): begin
        next_rdata[`BIT_TX_START:`BIT_TX_END] = dl_enable;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
    if (!mapped(s_axi_araddr)) begin
      next_rdata = 32'h00000000;
    end
  end

  // Registered data holds steady while rready is low
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (read_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status sources
  // ----------------------------------------------------------------
  // Kind latched at message end, so a read mid-message shows the last one
  always @(posedge aclk) begin
    if (!aresetn) begin
      message_kind <= 1'b0;
    end else if (ce && rx_message_done) begin
      message_kind <= rx_message_kind;
    end
  end

  los_change_detect u_los (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .los_level(rx_los),
    .los_change(los_change)
  );

  // Flags ignore bus writes; only a read of their register clears them
  event_flag u_los_flag (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .event_in(los_change),
    .clear(clear_los),
    .flag(los_flag)
  );

  event_flag u_tx_start (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .event_in(tx_start_event),
    .clear(clear_dl),
    .flag(tx_start_flag)
  );

  event_flag u_rx_start (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .event_in(rx_start_event),
    .clear(clear_dl),
    .flag(rx_start_flag)
  );

  event_flag u_tx_end (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .event_in(tx_end_event),
    .clear(clear_dl),
    .flag(tx_end_flag)
  );

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Registered so the pin never glitches from decode
  assign next_irq = (los_flag & !los_enable_n)
    | (tx_start_flag & dl_enable[2])
    | (rx_start_flag & dl_enable[1])
    | (tx_end_flag & dl_enable[0]);

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= next_irq;
    end
  end

endmodule

/* File: src/datalink_status_irq_regs.vh */
// Register map, field positions and reset values of the data-link status block
`ifndef DATALINK_STATUS_IRQ_REGS_VH
`define DATALINK_STATUS_IRQ_REGS_VH

// ----------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------
`define ADDR_LOS_IRQ_ENABLE 8'h00
`define ADDR_DATALINK2_STATUS 8'h04
`define ADDR_LOS_STATUS 8'h08
`define ADDR_DATALINK2_IRQ_ENABLE 8'h0C
`define ADDR_LSB 2
`define ADDR_MSB 7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_LOS_ENABLE 3
`define BIT_LOS_CHANGE 3
`define BIT_MESSAGE_KIND 7
`define BIT_TX_START 6
`define BIT_RX_START 5
`define BIT_TX_END 4

// ----------------------------------------------------------------
// Reset values and answers
// ----------------------------------------------------------------
`define RST_LOS_ENABLE 1'b1
`define RST_FLAG 1'b0
`define RST_DL_ENABLE 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: src/event_flag.v */
// One sticky event flag, cleared by a register read
`timescale 1ns/100ps
module event_flag (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire event_in,
  input wire clear,
  output reg flag
);
`include "datalink_status_irq_regs.vh"

  // Set beats clear so an event in the read cycle survives
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag <= `RST_FLAG;
    end else if (ce) begin
      if (event_in) begin
        flag <= 1'b1;
      end else if (clear) begin
        flag <= 1'b0;
      end
    end
  end
endmodule

/* File: src/los_change_detect.v */
// Edge detector on the receive loss-of-signal level
`timescale 1ns/100ps
module los_change_detect (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire los_level,
  output wire los_change
);

  reg los_prev;
  reg primed;

  // Primed after reset so a high level at start does not look like a change
  always @(posedge aclk) begin
    if (!aresetn) begin
      los_prev <= 1'b0;
      primed <= 1'b0;
    end else if (ce) begin
      los_prev <= los_level;
      primed <= 1'b1;
    end
  end

  // Both declare and clear count as a change
  assign los_change = ce & primed & (los_prev ^ los_level);
endmodule

/* File: tb/datalink_status_irq_assertions.sv */
// Bus handshake and read-data assertions for the data-link register block
`timescale 1ns/100ps
module dl_checker (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while busy");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready while busy");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("b repeated");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr >= 8'h10 |=> s_axi_rresp == 2'h2
    && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_upper_zero: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits");
  a_ce_ready: assert property (!ce |-> !s_axi_awready && !s_axi_wready
    && !s_axi_arready) else $error("ready while frozen");
  a_enable_read: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 8'h00 |=> s_axi_rdata[7:4] == 4'h0
    && s_axi_rdata[2:0] == 3'h0) else $error("enable reserved bits");
  a_los_read: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 8'h08 |=> s_axi_rdata[7:4] == 4'h0
    && s_axi_rdata[2:0] == 3'h0) else $error("los reserved bits");
endmodule

bind datalink_status_irq dl_checker i_dl_checker (.aclk, .aresetn, .ce,
  .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

/* File: tb/hdlc_partner.sv */
// Far-side model: data-link engines and receive line condition
`timescale 1ns/100ps
module hdlc_partner (
  input wire aclk,
  output reg rx_los,
  output wire tx_start_event,
  output wire rx_start_event,
  output wire tx_end_event,
  output reg rx_message_done,
  output reg rx_message_kind
);
  reg [2:0] ev = 3'h0;
  assign {tx_end_event, rx_start_event, tx_start_event} = ev;
  initial begin
    rx_los = 1'b0;
    rx_message_done = 1'b0;
    rx_message_kind = 1'b1;
  end
  // One-cycle event pulses, as the engines give them
  task automatic pulse(input [2:0] m);
    @(posedge aclk) ev <= m;
    @(posedge aclk) ev <= 3'h0;
  endtask
  // Kind is only valid with done; idle shows the inverse
  task automatic rx_msg(input k);
    pulse(3'h2);
    repeat (4) @(posedge aclk);
    rx_message_done <= 1'b1;
    rx_message_kind <= k;
    @(posedge aclk) rx_message_done <= 1'b0;
    rx_message_kind <= ~k;
  endtask
  task automatic los(input v);
    @(posedge aclk) rx_los <= v;
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the data-link status register block
`timescale 1ns/100ps
module tb;
  reg aclk = 0;
  reg aresetn = 0;
  reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg s_axi_arvalid = 0, s_axi_rready = 0;
  reg ce = 1;
  reg [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, irq, rx_los, rx_message_done, rx_message_kind;
  wire tx_start_event, rx_start_event, tx_end_event;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer fails = 0, samples_checked = 0;
  always #12.5 aclk = ~aclk;
  datalink_status_irq i_datalink_status_irq (.aclk, .aresetn,
    .ce, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_los, .tx_start_event, .rx_start_event,
    .tx_end_event, .rx_message_done, .rx_message_kind, .irq);
  hdlc_partner i_hdlc_partner (.aclk, .rx_los, .tx_start_event,
    .rx_start_event, .tx_end_event, .rx_message_done,
    .rx_message_kind);
  task close_out;
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Ready is sampled mid-cycle so the edge decision is race free
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] e);
    integer n;
    reg ah, wh, got;
    reg [1:0] r;
    got = 0;
    @(posedge aclk) s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 40 && !got; n = n + 1) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      got = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 0;
      if (wh) s_axi_wvalid <= 0;
      if (got) s_axi_bready <= 0;
    end
    if (!got) begin
      fails = fails + 1;
      close_out;
    end
    check({30'h0, r}, {30'h0, e});
  endtask
  task automatic rd(input [7:0] a, input [31:0] e, input [1:0] er);
    integer n;
    reg ah, got;
    reg [1:0] r;
    reg [31:0] d;
    got = 0;
    @(posedge aclk) s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 40 && !got; n = n + 1) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 0;
      if (got) s_axi_rready <= 0;
    end
    if (!got) begin
      fails = fails + 1;
      close_out;
    end
    check(d, e);
    check({30'h0, r}, {30'h0, er});
  endtask
  task automatic irq_is(input v);
    repeat (3) @(negedge aclk);
    check({31'h0, irq}, {31'h0, v});
  endtask
  task s_reset;
    rd(8'h00, 32'h08, 2'h0);
    rd(8'h04, 32'h00, 2'h0);
  endtask
  task s_tx;
    wr(8'h0C, 32'h70, 2'h0);
    rd(8'h0C, 32'h70, 2'h0);
    i_hdlc_partner.pulse(3'h1);
    irq_is(1);
    rd(8'h04, 32'h40, 2'h0);
    i_hdlc_partner.pulse(3'h4);
    rd(8'h04, 32'h10, 2'h0);
    rd(8'h04, 32'h00, 2'h0);
  endtask
  task s_rx;
    i_hdlc_partner.rx_msg(1);
    rd(8'h04, 32'hA0, 2'h0);
    rd(8'h04, 32'h80, 2'h0);
    wr(8'h04, 32'h00, 2'h0);
    rd(8'h04, 32'h80, 2'h0);
    wr(8'h0C, 32'h00, 2'h0);
    i_hdlc_partner.rx_msg(0);
    irq_is(0);
    rd(8'h04, 32'h20, 2'h0);
  endtask
  task s_los;
    wr(8'h00, 32'h00, 2'h0);
    i_hdlc_partner.los(1);
    irq_is(1);
    rd(8'h08, 32'h08, 2'h0);
    i_hdlc_partner.los(0);
    irq_is(1);
    rd(8'h08, 32'h08, 2'h0);
    wr(8'h00, 32'h08, 2'h0);
    i_hdlc_partner.los(1);
    irq_is(0);
    rd(8'h08, 32'h08, 2'h0);
  endtask
  task s_bad;
    rd(8'h10, 32'h00, 2'h2);
    rd(8'h06, 32'h00, 2'h2);
    wr(8'h12, 32'h00, 2'h2);
    rd(8'h00, 32'h08, 2'h0);
    s_axi_wstrb <= 4'hE;
    wr(8'h00, 32'h00, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h00, 32'h08, 2'h0);
  endtask
  // An event while frozen is lost, and no ready stands
  task s_ce;
    @(posedge aclk) ce <= 0;
    i_hdlc_partner.pulse(3'h1);
    @(negedge aclk);
    check({29'h0, s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0);
    @(posedge aclk) ce <= 1;
    rd(8'h04, 32'h00, 2'h0);
  endtask
  // Reset in mid-run, with a flag set, LOS high and LOS enabled
  task s_rst;
    wr(8'h00, 32'h00, 2'h0);
    i_hdlc_partner.pulse(3'h1);
    @(posedge aclk) aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(8'h04, 32'h00, 2'h0);
    rd(8'h00, 32'h08, 2'h0);
    rd(8'h08, 32'h00, 2'h0);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    s_reset;
    s_tx;
    s_rx;
    s_los;
    s_bad;
    s_ce;
    s_rst;
    close_out;
  end
endmodule
